// File: src/frw_ctrl.sv
// flash read-while-write sequencer with reset vector selection
`timescale 1ns/10ps
`default_nettype none
module frw_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic boot_vector_select_fuse,
    input wire logic op_req,
    input wire frw_pkg::frw_op_t op_kind,
    input wire logic [frw_pkg::ADDR_W-1:0] page_address_pointer,
    input wire logic busy_clear,
    input wire logic fetch_req,
    input wire logic [frw_pkg::ADDR_W-1:0] fetch_addr,
    output logic cpu_halt,
    output logic section_busy_flag,
    output logic op_active,
    output logic [frw_pkg::ADDR_W-1:0] latched_page_addr,
    output logic [frw_pkg::ADDR_W-1:0] reset_vector,
    output logic fetch_grant,
    output logic fetch_blocked,
    output logic flash_erase,
    output logic flash_write
);
    import frw_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum {ST_IDLE, ST_BUSY} frw_st_t;

    typedef struct packed {
        frw_st_t st;
        // two-flop synchroniser on the fuse pin
        logic fuse_m;
        logic fuse_s;
        // shift of ones, top bit set once fuse_s holds the pin level
        logic [1:0] settle;
        logic vec_loaded;
        logic stall_op;
        frw_op_t kind;
        logic busy;
        logic halt;
        logic [ADDR_W-1:0] page;
        logic [ADDR_W-1:0] vec;
        logic grant;
        logic blocked;
        logic active;
        logic erase;
        logic write;
    } frw_state_t;

    frw_state_t s_q;
    frw_state_t s_d;
    frw_timer_if tif ();

    // timer counts one page operation; its done lasts a single cycle
    frw_op_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .t(tif)
    );

    logic target_stall;
    logic fetch_stall;
    logic op_start;
    logic start_rww;
    logic [15:0] op_cycles;

    // boot section lies above STALL_START, so it is always in stall_section
    assign target_stall = (page_address_pointer >= STALL_START); // [R6]
    assign fetch_stall = (fetch_addr >= STALL_START);
    // a request while an operation runs is dropped, not queued
    assign op_start = op_req && (op_kind != FRW_OP_NONE) && (s_q.st == ST_IDLE);
    assign start_rww = op_start && !target_stall; // [R14]

    // ------------------------------------------------------------
    // operation length
    // ------------------------------------------------------------
    always_comb
    begin
        if (op_kind == FRW_OP_WRITE)
            op_cycles = WRITE_CYCLES;
        else
            op_cycles = ERASE_CYCLES;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        tif.start = 1'b0;
        tif.cycles = op_cycles;

        // ------------------------------------------------------------
        // reset vector
        // ------------------------------------------------------------
        s_d.fuse_m = boot_vector_select_fuse;
        s_d.fuse_s = s_q.fuse_m;
        s_d.settle = {s_q.settle[0], 1'b1};
        // fuse is only an input, nothing here can write it [R10]
        // taken once per reset, after the synchroniser holds the real level
        if (!s_q.vec_loaded && s_q.settle[1])
        begin
            s_d.vec_loaded = 1'b1;
            if (s_q.fuse_s == FUSE_PROGRAMMED)
                s_d.vec = BOOT_START; // [R8] [R13]
            else
                s_d.vec = APP_RESET_ADDR; // [R9]
        end

        // ------------------------------------------------------------
        // page operation
        // ------------------------------------------------------------
        case (s_q.st)
            ST_IDLE:
            begin
                if (op_start)
                begin
                    s_d.st = ST_BUSY;
                    s_d.kind = op_kind;
                    s_d.page = page_address_pointer; // [R12]
                    s_d.stall_op = target_stall;
                    tif.start = 1'b1;
                    if (target_stall)
                        s_d.halt = 1'b1; // [R5]
                    else
                        s_d.busy = 1'b1; // [R14]
                end
            end
            ST_BUSY:
            begin
                // halt and the stall marker drop with the last timer cycle
                if (tif.done)
                begin
                    s_d.st = ST_IDLE;
                    s_d.kind = FRW_OP_NONE;
                    s_d.halt = 1'b0;
                    s_d.stall_op = 1'b0;
                end
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // busy flag
        // ------------------------------------------------------------
        // flag holds after completion until cleared; set wins over clear [R4]
        // a clear during a running operation is ignored
        if (busy_clear && s_q.st == ST_IDLE && !start_rww)
            s_d.busy = 1'b0;

        // ------------------------------------------------------------
        // fetch arbitration
        // ------------------------------------------------------------
        // answered against the next state, so a fetch in the edge an
        // operation starts is already refused for it [R1] [R3] [R5]
        s_d.grant = 1'b0;
        s_d.blocked = 1'b0;
        if (fetch_req)
        begin
            if (s_d.halt)
                s_d.blocked = 1'b1;
            else if (!fetch_stall && s_d.busy)
                s_d.blocked = 1'b1; // [R2]
            else
                s_d.grant = 1'b1; // [R1]
        end

        // ------------------------------------------------------------
        // registered status
        // ------------------------------------------------------------
        s_d.active = (s_d.st == ST_BUSY);
        s_d.erase = (s_d.kind == FRW_OP_ERASE);
        s_d.write = (s_d.kind == FRW_OP_WRITE);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_q.st <= ST_IDLE;
            s_q.fuse_m <= 1'b1;
            s_q.fuse_s <= 1'b1;
            s_q.settle <= 2'h0;
            s_q.vec_loaded <= 1'b0;
            s_q.stall_op <= 1'b0;
            s_q.kind <= FRW_OP_NONE;
            s_q.busy <= 1'b0;
            s_q.halt <= 1'b0;
            s_q.page <= '0;
            s_q.vec <= APP_RESET_ADDR;
            s_q.grant <= 1'b0;
            s_q.blocked <= 1'b0;
            s_q.active <= 1'b0;
            s_q.erase <= 1'b0;
            s_q.write <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cpu_halt = s_q.halt;
    assign section_busy_flag = s_q.busy; // [R3]
    assign op_active = s_q.active;
    assign latched_page_addr = s_q.page;
    assign reset_vector = s_q.vec;
    assign fetch_grant = s_q.grant;
    assign fetch_blocked = s_q.blocked;
    assign flash_erase = s_q.erase;
    assign flash_write = s_q.write;
endmodule // frw_ctrl
`default_nettype wire

// File: src/frw_op_timer.sv
// down counter that times one page operation
`timescale 1ns/10ps
`default_nettype none
module frw_op_timer (
    input wire logic mclk,
    input wire logic rst,
    frw_timer_if.tmr t
);
    typedef struct packed {
        logic [15:0] cnt;
        logic run;
        logic done;
    } frw_tmr_state_t;

    frw_tmr_state_t s_q;
    frw_tmr_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (t.start)
        begin
            s_d.cnt = t.cycles;
            s_d.run = 1'b1;
        end
        else if (s_q.run)
        begin
            if (s_q.cnt <= 16'h0001)
            begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign t.done = s_q.done;
endmodule // frw_op_timer
`default_nettype wire

// File: src/frw_pkg.sv
// constants and types for the flash read-while-write controller
// Summary of operation
// (R1) programming the concurrent_read_section keeps stall_section code reads served, cpu running
// (R2) cpu must not fetch from concurrent_read_section while it is being programmed
// (R3) section_busy_flag reads one while concurrent_read_section is blocked for reading
// (R4) section_busy_flag stays set after programming until software clears it
// (R5) programming the stall_section halts the cpu; no section readable meanwhile
// (R6) the whole boot loader section lies inside the stall_section
// (R7) software should disable or relocate interrupts while programming concurrent_read_section
// (R8) programmed boot_vector_select_fuse starts execution at boot flash start after reset
// (R9) unprogrammed fuse (1) fetches reset vector from word address 0x0000
// (R10) the cpu cannot alter any fuse; only external programming changes it
// (R11) software enters boot loader by jump or call from the application
// (R12) target page address is latched when a programming operation starts
// (R13) fuse value 0 selects the boot loader reset vector
// (R14) section_busy_flag is set when any operation targets concurrent_read_section
package frw_pkg;
    localparam int ADDR_W = 15;
    localparam int PAGE_W = 6;
    localparam logic [ADDR_W-1:0] APP_RESET_ADDR = 15'h0000;
    localparam logic [ADDR_W-1:0] STALL_START = 15'h7000;
    localparam logic [ADDR_W-1:0] BOOT_START = 15'h7800;
    localparam logic [15:0] ERASE_CYCLES = 16'h0fa0;
    localparam logic [15:0] WRITE_CYCLES = 16'h0fa0;
    localparam logic FUSE_PROGRAMMED = 1'b0;

    typedef enum logic [1:0] {
        FRW_OP_NONE,
        FRW_OP_ERASE,
        FRW_OP_WRITE
    } frw_op_t;
endpackage : frw_pkg

// File: src/frw_timer_if.sv
// interface between controller and operation timer
`timescale 1ns/10ps
`default_nettype none
interface frw_timer_if;
    logic start;
    logic [15:0] cycles;
    logic done;
    modport ctrl (output start, output cycles, input done);
    modport tmr (input start, input cycles, output done);
endinterface : frw_timer_if
`default_nettype wire

// File: testbench/frw_checker.sv
// port checks for the flash read-while-write controller
`timescale 1ns/10ps
`default_nettype none
module frw_checker
    import frw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic boot_vector_select_fuse,
    input wire logic op_req,
    input wire frw_op_t op_kind,
    input wire logic [ADDR_W-1:0] page_address_pointer,
    input wire logic busy_clear,
    input wire logic fetch_req,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic cpu_halt,
    input wire logic section_busy_flag,
    input wire logic op_active,
    input wire logic [ADDR_W-1:0] latched_page_addr,
    input wire logic [ADDR_W-1:0] reset_vector,
    input wire logic fetch_grant,
    input wire logic fetch_blocked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [2:0] rel_q;
    logic go;
    assign go = op_req && !op_active && op_kind != FRW_OP_NONE;
    // edges since reset release, saturating once the fuse has settled
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            rel_q <= 3'h0;
        else if (rel_q != 3'h4)
            rel_q <= rel_q + 3'h1;
    chk_stall_halt: assert property (go && page_address_pointer >= STALL_START |=> cpu_halt && op_active)
        else $error("stall op did not halt");
    chk_rww_busy: assert property (go && page_address_pointer < STALL_START |=> section_busy_flag && !cpu_halt)
        else $error("busy not set or cpu halted");
    chk_busy_sticky: assert property (section_busy_flag && !(busy_clear && !op_active) |=> section_busy_flag)
        else $error("busy dropped without clear");
    chk_halt_blocks: assert property (fetch_req |=> !cpu_halt || (fetch_blocked && !fetch_grant))
        else $error("fetch served while halted");
    chk_stall_read: assert property (fetch_req && fetch_addr >= STALL_START |=> cpu_halt || fetch_grant)
        else $error("stall section fetch not granted");
    chk_rww_blocked: assert property (fetch_req && fetch_addr < STALL_START |=> !section_busy_flag || fetch_blocked)
        else $error("busy section fetch not blocked");
    chk_page_latch: assert property (go |=> latched_page_addr == $past(page_address_pointer))
        else $error("page not latched");
    chk_page_held: assert property (op_active && $past(op_active) |-> $stable(latched_page_addr))
        else $error("latched page moved");
    chk_reset_vec: assert property (rel_q == 3'h4 |-> reset_vector == (boot_vector_select_fuse ? APP_RESET_ADDR : BOOT_START))
        else $error("wrong reset vector");
endmodule // frw_checker
bind frw_ctrl frw_checker i_frw_checker (.*);
`default_nettype wire

// File: testbench/frw_cpu_model.sv
// processor-side fetch model for the flash read-while-write controller
`timescale 1ns/10ps
`default_nettype none
module frw_cpu_model
    import frw_pkg::*;
(
    input wire logic mclk,
    input wire logic en,
    input wire logic rogue,
    input wire logic busy,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic fetch_req,
    output logic [ADDR_W-1:0] fetch_addr
);
    logic [ADDR_W-1:0] last_q = 15'h0000;
    // busy section left alone unless a rogue fetch is ordered
    assign fetch_req = en && (rogue || !busy || addr_in >= STALL_START);
    // idle address shows the inverse of the last one
    assign fetch_addr = fetch_req ? addr_in : ~last_q;
    always @(posedge mclk)
        if (fetch_req)
            last_q <= fetch_addr;
endmodule // frw_cpu_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking testbench for the flash read-while-write controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    import frw_pkg::*;
    logic mclk = 0, rst = 1, boot_vector_select_fuse = 1, op_req = 0, busy_clear = 0, en = 0, rogue = 0;
    frw_op_t op_kind = FRW_OP_NONE;
    logic [ADDR_W-1:0] page_address_pointer = 15'h0000, want = 15'h0000, fetch_addr, latched_page_addr, reset_vector;
    logic fetch_req, cpu_halt, section_busy_flag, op_active, fetch_grant, fetch_blocked, flash_erase, flash_write;
    int miscompares = 0, checks = 0, cyc = 0, n;
    frw_ctrl i_frw_ctrl (.*);
    frw_cpu_model i_frw_cpu_model (.mclk, .en, .rogue, .busy(section_busy_flag), .addr_in(want), .fetch_req, .fetch_addr);
    initial forever #20 mclk = ~mclk;
    task chk(input string s, input logic [14:0] seen, input logic [14:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            close_out();
        end
    end
    task start_op(input frw_op_t k, input logic [14:0] a);
        @(negedge mclk);
        op_req = 1;
        op_kind = k;
        page_address_pointer = a;
        @(negedge mclk);
        op_req = 0;
        page_address_pointer = 15'h1234;
    endtask
    task wait_end();
        n = 0;
        while (op_active === 1'b1 && n < 5000)
        begin
            n++;
            @(negedge mclk);
        end
    endtask
    task t_vec(input logic f);
        rst = 1;
        boot_vector_select_fuse = f;
        repeat (4) @(negedge mclk);
        rst = 0;
        repeat (4) @(negedge mclk);
        chk("vector", reset_vector, f ? APP_RESET_ADDR : BOOT_START);
    endtask
    task t_rww();
        start_op(FRW_OP_ERASE, 15'h0100);
        chk("busy", section_busy_flag, 15'h0001);
        chk("halt", cpu_halt, 15'h0000);
        chk("erase", flash_erase, 15'h0001);
        want = BOOT_START;
        en = 1;
        @(negedge mclk);
        chk("grant", fetch_grant, 15'h0001);
        rogue = 1;
        want = 15'h0010;
        @(negedge mclk);
        chk("blocked", fetch_blocked, 15'h0001);
        en = 0;
        rogue = 0;
        start_op(FRW_OP_WRITE, 15'h7000);
        chk("halt", cpu_halt, 15'h0000);
        chk("latched", latched_page_addr, 15'h0100);
        wait_end();
        chk("busy_kept", section_busy_flag, 15'h0001);
        busy_clear = 1;
        @(negedge mclk);
        busy_clear = 0;
        chk("busy_clr", section_busy_flag, 15'h0000);
    endtask
    task t_stall();
        start_op(FRW_OP_WRITE, 15'h7040);
        chk("halt", cpu_halt, 15'h0001);
        chk("write", flash_write, 15'h0001);
        want = BOOT_START;
        en = 1;
        @(negedge mclk);
        chk("blocked", fetch_blocked, 15'h0001);
        en = 0;
        wait_end();
        // op_active stands from the start edge until one edge past the count
        chk("op_len", n[14:0] + 15'h0001, WRITE_CYCLES[14:0] + 15'h0001);
        chk("halt_end", cpu_halt, 15'h0000);
    endtask
    initial
    begin
        t_vec(1'b0);
        t_vec(1'b1);
        t_rww();
        t_stall();
        close_out();
    end
endmodule // tb
`default_nettype wire
